// ---- src/twaf_engine.sv ----
// Two-wire bus protocol engine: master with arbitration and clock sync, plus slave-receiver.
// Assumes open-drain pads outside; i_lclk runs the bus side, i_mclk the command side.
`timescale 1ns/100ps
`include "twaf_params.svh"

module twaf_engine
  import twaf_pkg::*;
#(
  parameter logic [6:0]  OWN_ADDR = `TWAF_OWN_ADDR,
  parameter int unsigned TLOW     = `TWAF_TLOW_CYC,
  parameter int unsigned THIGH    = `TWAF_THIGH_CYC,
  parameter int unsigned TBUF     = `TWAF_TBUF_CYC,
  parameter int unsigned TSU      = `TWAF_TSU_CYC,
  parameter int unsigned THD      = `TWAF_THD_CYC,
  parameter int unsigned THDDAT   = `TWAF_THDDAT_CYC
) (
  input  wire logic      i_mclk,
  input  wire logic      i_lclk,
  input  wire logic      i_nrst,
  input  wire logic      i_scl_in,
  input  wire logic      i_sda_in,
  output logic           o_scl_out,
  output logic           o_scl_oe,
  output logic           o_sda_out,
  output logic           o_sda_oe,
  input  wire logic      i_cmd_valid,
  input  twaf_cmd_t      i_cmd,
  output logic           o_cmd_ready,
  output logic           o_rsp_valid,
  output twaf_rsp_t      o_rsp,
  output logic           o_srx_valid,
  output twaf_srx_t      o_srx
);

  localparam logic [11:0] TLOW_M1   = 12'(TLOW - 1);
  localparam logic [11:0] THIGH_M1  = 12'(THIGH - 1);
  localparam logic [11:0] TBUF_C    = 12'(TBUF);
  localparam logic [11:0] TSU_M1    = 12'(TSU - 1);
  localparam logic [11:0] THD_M1    = 12'(THD - 1);
  localparam logic [11:0] THDDAT_C  = 12'(THDDAT);

  twaf_lnk_t l;
  twaf_lnk_t n;
  twaf_sys_t m;
  twaf_sys_t nm;

  logic      scl_s;
  logic      scl_p;
  logic      sda_s;
  logic      sda_p;
  logic      start_det;
  logic      stop_det;
  logic      scl_fall;
  logic      scl_rise;
  logic      pend;
  logic      free;
  logic      lost;
  logic      bit_end;
  logic      fin;
  twaf_rsp_t fin_rsp;

  // Edges come from the second and third sync stages only
  assign scl_s     = l.scl_q[1];
  assign scl_p     = l.scl_q[2];
  assign sda_s     = l.sda_q[1];
  assign sda_p     = l.sda_q[2];
  assign start_det = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_det  = scl_s & scl_p & ~sda_p & sda_s;
  assign scl_fall  = scl_p & ~scl_s;
  assign scl_rise  = ~scl_p & scl_s;
  assign pend      = l.req_q[1] ^ l.req_seen;
  assign free      = ~l.busy & (l.bufc == TBUF_C);
  // Only bits this master sends are compared; read bits and ack slots are not
  assign lost      = (l.st == TS_HIGH) & scl_s & ~l.sda_oe & ~sda_s & ~l.rd & (l.bitc != `TWAF_ACK_BIT);
  // Bit ends on own high count or when a faster master pulls SCL low
  assign bit_end   = (l.st == TS_HIGH) & (scl_fall | (l.cnt == THIGH_M1));

  // Link side next state
  always_comb begin
    n = l;
    fin = 1'b0;
    fin_rsp = '0;
    n.scl_q = {l.scl_q[1:0], i_scl_in};
    n.sda_q = {l.sda_q[1:0], i_sda_in};
    n.req_q = {l.req_q[0], m.req_tgl};
    n.cnt = l.cnt + 12'h001;
    // Bus counts as free only a full bus-free time after STOP or reset
    if (start_det) begin
      n.busy = 1'b1;
    end else if (stop_det) begin
      n.busy = 1'b0;
      n.bufc = '0;
    end else if (l.bufc != TBUF_C) begin
      n.bufc = l.bufc + 12'h001;
    end
    case (l.st)
      TS_IDLE: begin
        n.own = 1'b0;
        n.scl_oe = 1'b0;
        n.sda_oe = 1'b0;
        if (start_det) begin
          n.st = TS_SLV;
          n.bitc = '0;
          n.addr_ph = 1'b1;
          n.slv_sel = 1'b0;
        end else if (pend && m.cmd.op != TWAF_OP_START) begin
          fin = 1'b1;
          fin_rsp.err = 1'b1;
        end else if (pend && free) begin
          n.sda_oe = 1'b1;
          n.cnt = '0;
          n.txb = m.cmd.data;
          n.st = TS_ST;
        end
      end
      TS_SLV: begin
        if (start_det) begin
          n.bitc = '0;
          n.addr_ph = 1'b1;
          n.slv_sel = 1'b0;
          n.ack_drv = 1'b0;
          n.sda_oe = 1'b0;
        end else if (stop_det) begin
          n.st = TS_IDLE;
          n.sda_oe = 1'b0;
          n.slv_sel = 1'b0;
          n.ack_drv = 1'b0;
        end else if (scl_rise && l.bitc != `TWAF_ACK_BIT) begin
          n.rxb = {l.rxb[6:0], sda_s};
        end else if (scl_fall && l.bitc == `TWAF_ACK_BIT) begin
          // Ack slot over: release SDA so the master can go on or stop
          n.bitc = '0;
          n.sda_oe = 1'b0;
          n.ack_drv = 1'b0;
          n.addr_ph = 1'b0;
        end else if (scl_fall) begin
          n.bitc = l.bitc + 4'h1;
          if (l.bitc == `TWAF_LAST_BIT && l.addr_ph) begin
            // Write to own address only; reads and the alternate format stay unanswered
            n.slv_sel = (l.rxb[7:1] == OWN_ADDR) & ~l.rxb[0] & (l.rxb[7:1] != `TWAF_ALT_ADDR);
            n.ack_drv = n.slv_sel;
            n.sda_oe = n.slv_sel;
            n.first_dat = 1'b1;
          end else if (l.bitc == `TWAF_LAST_BIT && l.slv_sel) begin
            n.ack_drv = 1'b1;
            n.sda_oe = 1'b1;
            n.evt.data = l.rxb;
            n.evt.first = l.first_dat;
            n.evt_tgl = ~l.evt_tgl;
            n.first_dat = 1'b0;
          end
        end
      end
      TS_ST: begin
        // SDA low with SCL high; hold, then clock the address byte
        n.own = 1'b1;
        n.bitc = '0;
        n.addr_ph = 1'b1;
        n.rd = 1'b0;
        if (l.cnt == THD_M1) begin
          n.scl_oe = 1'b1;
          n.cnt = '0;
          n.st = TS_LOW;
        end
      end
      TS_LOW: begin
        n.scl_oe = 1'b1;
        // SDA moves a hold time after the fall, well inside the low phase
        if (l.cnt == THDDAT_C) begin
          if (l.bitc != `TWAF_ACK_BIT) begin
            n.sda_oe = ~l.rd & ~l.txb[7];
          end else begin
            n.sda_oe = l.rd & ~l.nack;
          end
        end
        if (l.cnt == TLOW_M1) begin
          n.scl_oe = 1'b0;
          n.st = TS_HWAIT;
        end
      end
      TS_HWAIT: begin
        // Slow slaves or masters may hold SCL; count high only once it is high
        n.cnt = '0;
        if (scl_s) begin
          n.st = TS_HIGH;
        end
      end
      TS_HIGH: begin
        if (lost) begin
          // Stop driving at once; slave side takes over during the address
          n.sda_oe = 1'b0;
          n.scl_oe = 1'b0;
          n.own = 1'b0;
          n.rxb = {l.rxb[6:0], 1'b0};
          n.slv_sel = 1'b0;
          n.st = l.addr_ph ? TS_SLV : TS_IDLE;
          fin = 1'b1;
          fin_rsp.lost = 1'b1;
        end else if (bit_end) begin
          n.scl_oe = 1'b1;
          n.cnt = '0;
          n.st = TS_LOW;
          if (l.bitc != `TWAF_ACK_BIT) begin
            n.rxb = {l.rxb[6:0], sda_s};
            n.txb = {l.txb[6:0], 1'b0};
            n.bitc = l.bitc + 4'h1;
          end else begin
            // Byte done: keep SCL low until the next command
            n.bitc = '0;
            n.addr_ph = 1'b0;
            n.last_ack_rd = l.rd & ~l.nack;
            n.st = TS_HOLD;
            fin = 1'b1;
            fin_rsp.data = l.rxb;
            fin_rsp.nack = sda_s;
          end
        end
      end
      TS_HOLD: begin
        n.scl_oe = 1'b1;
        n.cnt = '0;
        if (pend) begin
          case (m.cmd.op)
            TWAF_OP_WRITE: begin
              n.txb = m.cmd.data;
              n.rd = 1'b0;
              n.st = TS_LOW;
            end
            TWAF_OP_READ: begin
              n.rd = 1'b1;
              n.nack = m.cmd.nack;
              n.st = TS_LOW;
            end
            TWAF_OP_START: begin
              // Refused after an acknowledged read byte
              if (l.last_ack_rd) begin
                fin = 1'b1;
                fin_rsp.err = 1'b1;
              end else begin
                n.txb = m.cmd.data;
                n.stop_pend = 1'b0;
                n.st = TS_PREP;
              end
            end
            default: begin
              n.stop_pend = 1'b1;
              n.st = TS_PREP;
            end
          endcase
        end
      end
      TS_PREP: begin
        // SDA low for STOP, released for repeated START, both with SCL low
        n.scl_oe = 1'b1;
        if (l.cnt == THDDAT_C) begin
          n.sda_oe = l.stop_pend;
        end
        if (l.cnt == TLOW_M1) begin
          n.scl_oe = 1'b0;
          n.cnt = '0;
          n.st = TS_SU;
        end
      end
      TS_SU: begin
        if (!scl_s) begin
          n.cnt = '0;
        end else if (l.cnt == TSU_M1) begin
          n.cnt = '0;
          if (l.stop_pend) begin
            n.sda_oe = 1'b0;
            n.own = 1'b0;
            n.st = TS_IDLE;
            fin = 1'b1;
          end else begin
            n.sda_oe = 1'b1;
            n.st = TS_ST;
          end
        end
      end
      default: begin
        n.st = TS_IDLE;
      end
    endcase
    if (fin) begin
      n.rsp = fin_rsp;
      n.rsp_tgl = ~l.rsp_tgl;
      n.req_seen = l.req_q[1];
    end
  end

  // Link side register; reset values are constants, idle bus reads high
  always_ff @(posedge i_lclk or negedge i_nrst) begin
    if (!i_nrst) begin
      l <= '0;
      l.scl_q <= `TWAF_PIN_RST;
      l.sda_q <= `TWAF_PIN_RST;
      l.st <= TS_IDLE;
    end else begin
      l <= n;
    end
  end

  // System side: toggle handshake out, synced toggles back; link words are stable when read
  always_comb begin
    nm = m;
    nm.ack_q = {m.ack_q[1:0], l.rsp_tgl};
    nm.evt_q = {m.evt_q[1:0], l.evt_tgl};
    nm.rsp_valid = 1'b0;
    nm.srx_valid = 1'b0;
    if (m.ack_q[2] != m.ack_q[1]) begin
      nm.rsp_valid = 1'b1;
      nm.rsp = l.rsp;
      nm.pend = 1'b0;
    end
    if (m.evt_q[2] != m.evt_q[1]) begin
      nm.srx_valid = 1'b1;
      nm.srx = l.evt;
    end
    if (i_cmd_valid && m.cmd_ready) begin
      nm.cmd = i_cmd;
      nm.req_tgl = ~m.req_tgl;
      nm.pend = 1'b1;
    end
    // One command in flight; the next waits for its answer
    nm.cmd_ready = ~nm.pend;
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      m <= '0;
      m.cmd_ready <= 1'b1;
    end else begin
      m <= nm;
    end
  end

  // Outputs straight from flip-flops; pads pull low only
  assign o_scl_out   = l.pin_lvl;
  assign o_scl_oe    = l.scl_oe;
  assign o_sda_out   = l.pin_lvl;
  assign o_sda_oe    = l.sda_oe;
  assign o_cmd_ready = m.cmd_ready;
  assign o_rsp_valid = m.rsp_valid;
  assign o_rsp       = m.rsp;
  assign o_srx_valid = m.srx_valid;
  assign o_srx       = m.srx;

  // Checks on the link domain
  property p_ack_release;
    @(posedge i_lclk) disable iff (!i_nrst)
      (l.st == TS_HIGH && l.bitc == `TWAF_ACK_BIT && !l.rd) |-> !l.sda_oe;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("Transmitter drives SDA in ack slot");

  property p_ack_drive;
    @(posedge i_lclk) disable iff (!i_nrst)
      (l.st == TS_HIGH && l.bitc == `TWAF_ACK_BIT && l.rd) |-> (l.sda_oe == !l.nack);
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("Master receiver ack level wrong");

  property p_alt_noack;
    @(posedge i_lclk) disable iff (!i_nrst)
      (l.st == TS_SLV && scl_fall && l.addr_ph && l.bitc == `TWAF_LAST_BIT && !start_det && !stop_det)
        |=> (l.sda_oe == ($past(l.rxb[7:1]) == OWN_ADDR && !$past(l.rxb[0])));
  endproperty
  a_alt_noack: assert property (p_alt_noack) else $error("Address acknowledge wrong");

  property p_start_free;
    @(posedge i_lclk) disable iff (!i_nrst)
      (l.st == TS_IDLE ##1 l.st == TS_ST) |-> $past(free);
  endproperty
  a_start_free: assert property (p_start_free) else $error("START issued on busy bus");

  property p_arb_off;
    @(posedge i_lclk) disable iff (!i_nrst)
      lost |=> (!l.sda_oe && !l.scl_oe) ##1 (l.st == TS_SLV || l.st == TS_IDLE);
  endproperty
  a_arb_off: assert property (p_arb_off) else $error("Still driving after arbitration loss");

  property p_low_restart;
    @(posedge i_lclk) disable iff (!i_nrst)
      (l.st == TS_HIGH && scl_fall && !lost) |=> (l.st == TS_LOW && l.scl_oe && l.cnt == 12'h000);
  endproperty
  a_low_restart: assert property (p_low_restart) else $error("Low count not restarted");

  property p_hwait;
    @(posedge i_lclk) disable iff (!i_nrst)
      (l.st == TS_HWAIT && !scl_s) |=> (l.st == TS_HWAIT && !l.scl_oe && l.cnt == 12'h000);
  endproperty
  a_hwait: assert property (p_hwait) else $error("High count began with SCL low");

  property p_high_end;
    @(posedge i_lclk) disable iff (!i_nrst)
      (l.st == TS_HIGH && l.cnt == THIGH_M1 && !lost) |=> l.scl_oe;
  endproperty
  a_high_end: assert property (p_high_end) else $error("SCL not pulled low after high period");

  property p_start_reset;
    @(posedge i_lclk) disable iff (!i_nrst)
      (start_det && (l.st == TS_IDLE || l.st == TS_SLV)) |=> (l.st == TS_SLV && l.bitc == 4'h0 && l.addr_ph);
  endproperty
  a_start_reset: assert property (p_start_reset) else $error("START did not reset protocol state");

  property p_byte_len;
    @(posedge i_lclk) disable iff (!i_nrst)
      l.bitc <= `TWAF_ACK_BIT;
  endproperty
  a_byte_len: assert property (p_byte_len) else $error("Bit counter past ack slot");

  c_byte_done: cover property (@(posedge i_lclk) disable iff (!i_nrst) fin && !fin_rsp.lost && !fin_rsp.err);
  c_arb_addr:  cover property (@(posedge i_lclk) disable iff (!i_nrst) lost && l.addr_ph);
  c_slave_ack: cover property (@(posedge i_lclk) disable iff (!i_nrst) l.st == TS_SLV && l.ack_drv && l.slv_sel);

endmodule

// ---- src/twaf_params.svh ----
// Constants of the two-wire bus protocol engine: link timing and fixed codes.
// Assumes the link clock period below; cycle counts derive from it.
`ifndef TWAF_PARAMS_SVH
`define TWAF_PARAMS_SVH

// Link clock period in ns
`define TWAF_LCLK_NS    30
// Bus timing figures in ns (standard rate)
`define TWAF_TLOW_NS    4700
`define TWAF_THIGH_NS   4000
`define TWAF_TBUF_NS    4700
`define TWAF_TSU_NS     4700
`define TWAF_THD_NS     4000
`define TWAF_THDDAT_NS  300

// Least times, rounded up to whole link clock cycles
`define TWAF_TLOW_CYC   ((`TWAF_TLOW_NS + `TWAF_LCLK_NS - 1) / `TWAF_LCLK_NS)
`define TWAF_THIGH_CYC  ((`TWAF_THIGH_NS + `TWAF_LCLK_NS - 1) / `TWAF_LCLK_NS)
`define TWAF_TBUF_CYC   ((`TWAF_TBUF_NS + `TWAF_LCLK_NS - 1) / `TWAF_LCLK_NS)
`define TWAF_TSU_CYC    ((`TWAF_TSU_NS + `TWAF_LCLK_NS - 1) / `TWAF_LCLK_NS)
`define TWAF_THD_CYC    ((`TWAF_THD_NS + `TWAF_LCLK_NS - 1) / `TWAF_LCLK_NS)
`define TWAF_THDDAT_CYC ((`TWAF_THDDAT_NS + `TWAF_LCLK_NS - 1) / `TWAF_LCLK_NS)

// Bits per byte, index of the acknowledge slot
`define TWAF_ACK_BIT    4'h8
`define TWAF_LAST_BIT   4'h7
// Address of the alternate bus format, never acknowledged
`define TWAF_ALT_ADDR   7'h02
// Own slave address, arbitrary value
`define TWAF_OWN_ADDR   7'h3C
// Reset value of the pin synchronisers: idle bus reads high
`define TWAF_PIN_RST    3'h7

`endif

// ---- src/twaf_pkg.sv ----
// Types of the two-wire bus protocol engine.
// Assumes nothing beyond a SystemVerilog compiler.
package twaf_pkg;

  // Commands from the system side
  typedef enum logic [1:0] {
    TWAF_OP_START = 2'h0,
    TWAF_OP_WRITE = 2'h1,
    TWAF_OP_READ  = 2'h2,
    TWAF_OP_STOP  = 2'h3
  } twaf_op_t;

  typedef struct packed {
    twaf_op_t   op;
    logic [7:0] data;   // Byte to send; for START the address and direction
    logic       nack;   // For READ: answer the byte with not-acknowledge
  } twaf_cmd_t;

  typedef struct packed {
    logic [7:0] data;   // Byte received on the bus
    logic       nack;   // Level seen in the acknowledge slot
    logic       lost;   // Arbitration lost
    logic       err;    // Command refused
  } twaf_rsp_t;

  typedef struct packed {
    logic [7:0] data;
    logic       first;  // First data byte after the address
  } twaf_srx_t;

  // Link state machine, one-hot
  typedef enum logic [8:0] {
    TS_IDLE  = 9'h001,
    TS_SLV   = 9'h002,
    TS_ST    = 9'h004,
    TS_LOW   = 9'h008,
    TS_HWAIT = 9'h010,
    TS_HIGH  = 9'h020,
    TS_HOLD  = 9'h040,
    TS_PREP  = 9'h080,
    TS_SU    = 9'h100
  } twaf_st_t;

  // Link clock domain state
  typedef struct packed {
    logic [2:0] scl_q;
    logic [2:0] sda_q;
    logic [1:0] req_q;
    logic       req_seen;
    twaf_st_t   st;
    logic [11:0] cnt;
    logic [3:0] bitc;
    logic [7:0] txb;
    logic [7:0] rxb;
    logic       rd;
    logic       nack;
    logic       addr_ph;
    logic       stop_pend;
    logic       last_ack_rd;
    logic       own;
    logic       slv_sel;
    logic       ack_drv;
    logic       first_dat;
    logic       busy;
    logic [11:0] bufc;
    logic       scl_oe;
    logic       sda_oe;
    logic       pin_lvl;
    logic       rsp_tgl;
    twaf_rsp_t  rsp;
    logic       evt_tgl;
    twaf_srx_t  evt;
  } twaf_lnk_t;

  // System clock domain state
  typedef struct packed {
    logic       req_tgl;
    twaf_cmd_t  cmd;
    logic       pend;
    logic       cmd_ready;
    logic [2:0] ack_q;
    logic [2:0] evt_q;
    logic       rsp_valid;
    twaf_rsp_t  rsp;
    logic       srx_valid;
    twaf_srx_t  srx;
  } twaf_sys_t;

endpackage

// ---- sim/twaf_slave_model.sv ----
// Behavioural slave on the shared two-wire bus, far side of the protocol engine.
// Assumes pull-ups on both lines; the bench forms the wired-AND from all enables.
`timescale 1ns/100ps

module twaf_slave_model #(
  parameter logic [6:0] ADDR       = 7'h50,
  parameter logic [7:0] RDATA      = 8'hC5,
  parameter int         MAXB       = 1,
  parameter int         STRETCH_NS = 700
) (
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_scl_oe,
  output logic      o_sda_oe
);
  logic [7:0] sh;
  logic [3:0] bitc;
  logic       sel;
  logic       rd;
  logic       aph;
  logic       mack;
  int         nb;

  initial begin
    {o_scl_oe, o_sda_oe, sel, rd, aph, mack, bitc, sh, nb} = '0;
  end

  // START restarts framing and expects an address byte
  always @(negedge i_sda) if (i_scl) begin
    {bitc, sel, nb, o_sda_oe} = '0;
    aph = 1'b1;
  end

  // STOP ends any selection
  always @(posedge i_sda) if (i_scl) begin
    {sel, aph, o_sda_oe} = '0;
  end

  // Sample on SCL high, most significant bit first
  always @(posedge i_scl) begin
    if (bitc < 4'h8) sh = {sh[6:0], i_sda};
    else mack = i_sda;
    bitc = bitc + 4'h1;
  end

  // All SDA changes happen with SCL low
  always @(negedge i_scl) begin
    if (bitc == 4'h8 && (aph || (sel && !rd))) begin
      if (aph) begin
        sel = (sh[7:1] == ADDR); // Direction bit in the lsb
        rd  = sh[0];
      end else nb = nb + 1;
      o_sda_oe = aph ? sel : (nb <= MAXB); // Ack low, refusal left high
    end else if (bitc == 4'h8) begin
      o_sda_oe = 1'b0; // Transmitter frees SDA in the ack slot
    end else if (bitc == 4'h9) begin
      bitc     = 4'h0;
      aph      = 1'b0;
      o_sda_oe = 1'b0;
      if (sel) begin
        o_scl_oe = 1'b1; // Byte-level hold after each byte while selected, acked or not
        #(STRETCH_NS);
      end
      // Master nack ends the transmission and frees SDA
      if (sel && rd && !mack) o_sda_oe = ~RDATA[7];
      o_scl_oe = 1'b0;
    end else if (sel && rd && bitc != 4'h0) begin
      o_sda_oe = ~RDATA[4'h7 - bitc];
    end
  end
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench: engine as master against one slave model on a wired-AND bus.
// Assumes the engine's package and header on the include path.
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t: %h %h", $time, (a), (b)); end end

module testbench
  import twaf_pkg::*;
;
  localparam logic [7:0] RDATA = 8'hC5;
  logic        i_mclk = 1'b0;
  logic        i_lclk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_cmd_valid = 1'b0;
  twaf_cmd_t   i_cmd = '0;
  logic        m_scl_oe, m_sda_oe, s_scl_oe, s_sda_oe, scl_out, sda_out;
  logic        o_cmd_ready, o_rsp_valid, o_srx_valid;
  twaf_rsp_t   o_rsp;
  twaf_srx_t   o_srx;
  logic [10:0] exp_q[$];
  logic [10:0] msk_q[$];
  logic [10:0] e, m;
  int          n_mismatch = 0, total_checks = 0, seed = 38, cyc = 0, n;
  // Pull-ups make both lines high unless someone pulls low
  wire         scl = !(m_scl_oe || s_scl_oe);
  wire         sda = !(m_sda_oe || s_sda_oe);

  always #10 i_mclk = ~i_mclk;
  // Link clock offset so its edges never meet the system clock's
  initial begin
    #3.7;
    forever #15 i_lclk = ~i_lclk;
  end

  // Bus-free time keeps its default so the wait after reset and STOP is exercised at full length
  twaf_engine #(.TLOW(8), .THIGH(8), .TSU(8), .THD(8), .THDDAT(2)) u_twaf_engine (
    .i_mclk(i_mclk), .i_lclk(i_lclk), .i_nrst(i_nrst), .i_scl_in(scl), .i_sda_in(sda),
    .o_scl_out(scl_out), .o_scl_oe(m_scl_oe), .o_sda_out(sda_out), .o_sda_oe(m_sda_oe),
    .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready),
    .o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp), .o_srx_valid(o_srx_valid), .o_srx(o_srx));

  // Slave keeps its defaults: address 7'h50, read byte RDATA, one data byte taken
  twaf_slave_model u_twaf_slave_model (
    .i_scl(scl), .i_sda(sda), .o_scl_oe(s_scl_oe), .o_sda_oe(s_sda_oe));

  task automatic summarize();
    if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Issue one command once ready, noting the masked response it should give
  task automatic cmd(input twaf_op_t op, input logic [7:0] d, input logic nk,
                     input logic [10:0] ev, input logic [10:0] mv);
    n = 0;
    while (o_cmd_ready !== 1'b1 && n < 5000) begin
      @(posedge i_mclk);
      n++;
    end
    exp_q.push_back(ev);
    msk_q.push_back(mv);
    i_cmd_valid <= 1'b1;
    i_cmd       <= '{op, d, nk};
    @(posedge i_mclk);
    i_cmd_valid <= 1'b0;
    @(posedge i_mclk);
  endtask

  // Response watcher, sampling away from the launching edge
  always @(negedge i_mclk) if (o_rsp_valid === 1'b1) begin
    if (exp_q.size() == 0) n_mismatch++;
    else begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      `CHK(o_rsp & m, e & m)
    end
  end

  // A hang counts against the run
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    repeat (10) @(posedge i_mclk);
    i_nrst <= 1'b1;
    cmd(TWAF_OP_START, 8'hA0, 1'b0, 11'h000, 11'h007);
    cmd(TWAF_OP_WRITE, 8'($random(seed)), 1'b0, 11'h000, 11'h007);
    cmd(TWAF_OP_WRITE, 8'($random(seed)), 1'b0, 11'h004, 11'h007);
    cmd(TWAF_OP_STOP, 8'h00, 1'b0, 11'h000, 11'h001);
    cmd(TWAF_OP_WRITE, 8'($random(seed)), 1'b0, 11'h001, 11'h001);
    cmd(TWAF_OP_START, 8'hA1, 1'b0, 11'h000, 11'h007);
    cmd(TWAF_OP_READ, 8'h00, 1'b0, {RDATA, 3'h0}, 11'h7FF);
    cmd(TWAF_OP_START, 8'h22, 1'b0, 11'h001, 11'h001);
    cmd(TWAF_OP_READ, 8'h00, 1'b1, {RDATA, 3'h4}, 11'h7FF);
    cmd(TWAF_OP_START, 8'h22, 1'b0, 11'h004, 11'h007);
    cmd(TWAF_OP_STOP, 8'h00, 1'b0, 11'h000, 11'h001);
    cmd(TWAF_OP_START, 8'h04, 1'b0, 11'h004, 11'h007);
    cmd(TWAF_OP_STOP, 8'h00, 1'b0, 11'h000, 11'h001);
    n = 0;
    while (exp_q.size() > 0 && n < 5000) begin
      @(posedge i_mclk);
      n++;
    end
    if (exp_q.size() > 0) n_mismatch++;
    summarize();
  end
endmodule
